/* File: src/mrr_top.sv */
`timescale 1ns/1ps
`include "mrr_params.svh"
// mode register read-back path: decode, latency, eight-beat burst
module mrr_top #(
  parameter int unsigned READ_LAT = `MRR_READ_LAT,
  parameter int unsigned TSI_CYC  = `MRR_TSI_CYC,
  parameter int unsigned LANES    = 4
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // command bus pins, halves presented per cycle
  input  wire logic                 cs_b,
  input  wire logic [9:0]           ca_rise,
  input  wire logic [9:0]           ca_fall,
  // configuration registers of the device (byte view)
  input  wire logic [7:0]           cfg_byte,
  input  wire logic [7:0]           sensor_code,
  input  wire logic                 lp_exit,
  // data and strobe outputs
  output logic [8*LANES-1:0]        dq_out,
  output logic                      dq_oe,
  output logic [LANES-1:0]          dqs_out,
  output logic                      dqs_oe,
  // status
  output logic [7:0]                cfg_addr,
  output logic                      busy
);
  import mrr_pkg::*;
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops on command, sensor_code and lp_exit pins; cfg_byte goes to the engine unsynchronised
  logic        cs_m, cs_s;
  logic [9:0]  car_m, car_s, caf_m, caf_s;
  logic [7:0]  sen_m, sen_s;
  logic        lpx_m, lpx_s;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      car_m <= 10'h000;
      car_s <= 10'h000;
      caf_m <= 10'h000;
      caf_s <= 10'h000;
      sen_m <= 8'h00;
      sen_s <= 8'h00;
      lpx_m <= 1'b0;
      lpx_s <= 1'b0;
    end else begin
      cs_m <= cs_b;
      cs_s <= cs_m;
      car_m <= ca_rise;
      car_s <= car_m;
      caf_m <= ca_fall;
      caf_s <= caf_m;
      sen_m <= sensor_code;
      sen_s <= sen_m;
      lpx_m <= lp_exit;
      lpx_s <= lpx_m;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // sub-blocks
  mrr_req_if req ();
  logic [7:0] temp_status;
  mrr_decode u_dec (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .cs_b    (cs_s),
    .ca_rise (car_s),
    .ca_fall (caf_s),
    .req     (req)
  );
  mrr_temp #(.TSI_CYC(TSI_CYC)) u_temp (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .sensor_code (sen_s),
    .lp_exit     (lpx_s),
    .temp_status (temp_status)
  );
  ////////////////////////////////////////////////////////////////////
  // burst engine
  // one bit per beat; replicated on all eight lines of each lane
  function automatic logic [8*LANES-1:0] lane_fill(input logic b);
    lane_fill = {(8*LANES){b}};
  endfunction
  mrr_state_t          st_q, st_d;
  logic [7:0]          lat_q, lat_d;
  logic [3:0]          beat_q, beat_d;
  logic [7:0]          data_q, data_d;
  mrr_kind_t           kind_q, kind_d;
  logic [7:0]          addr_q, addr_d;
  logic [8*LANES-1:0]  dq_q, dq_d;
  logic                oe_q, oe_d;
  logic [LANES-1:0]    dqs_q, dqs_d;
  logic [7:0]          pat;
  // next state; controller keeps quiet during a read so requests mid-burst are ignored
  always_comb begin
    st_d   = st_q;
    lat_d  = lat_q;
    beat_d = beat_q;
    data_d = data_q;
    kind_d = kind_q;
    addr_d = addr_q;
    dq_d   = dq_q;
    oe_d   = 1'b0;
    dqs_d  = {LANES{1'b0}};
    pat    = (kind_q == MRR_K_PAT_A) ? `MRR_PAT_A : `MRR_PAT_B;
    unique case (st_q)
      MRR_IDLE: begin
        dq_d = '0;
        if (req.valid) begin
          addr_d = req.addr;
          kind_d = req.kind;
          // pick source byte: temperature status or configuration byte
          data_d = (req.addr == `MRR_ADDR_TEMP) ? temp_status : cfg_byte;
          lat_d  = 8'(READ_LAT);
          st_d   = MRR_WAIT;
        end
      end
      MRR_WAIT: begin
        // no new command is expected here
        lat_d = lat_q - 8'h01;
        if (lat_q <= 8'h01) begin
          st_d   = MRR_BURST;
          beat_d = 4'h0;
        end
      end
      MRR_BURST: begin
        oe_d  = 1'b1;
        dqs_d = {LANES{~beat_q[0]}};
        if (kind_q != MRR_K_PLAIN) begin
          dq_d = lane_fill(pat[beat_q[2:0]]);
        end else if (beat_q == 4'h0) begin
          dq_d = '0;
          dq_d[7:0] = data_q;
        end else begin
          dq_d = '0;
        end
        beat_d = beat_q + 4'h1;
        if (beat_q == `MRR_BEATS - 4'h1) begin
          st_d = MRR_IDLE;
        end
      end
      // two-bit state has one unused code; fall back to idle
      default: begin
        st_d = MRR_IDLE;
      end
    endcase
  end
  // register the engine
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= MRR_IDLE;
      lat_q  <= 8'h00;
      beat_q <= 4'h0;
      data_q <= 8'h00;
      kind_q <= MRR_K_PLAIN;
      addr_q <= 8'h00;
      dq_q   <= '0;
      oe_q   <= 1'b0;
      dqs_q  <= '0;
    end else begin
      st_q   <= st_d;
      lat_q  <= lat_d;
      beat_q <= beat_d;
      data_q <= data_d;
      kind_q <= kind_d;
      addr_q <= addr_d;
      dq_q   <= dq_d;
      oe_q   <= oe_d;
      dqs_q  <= dqs_d;
    end
  end
  // busy flag registered from next state so it stays a flop output
  logic busy_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else begin
      // the last beat is still on the pins when the engine returns to idle
      busy_q <= (st_d != MRR_IDLE) || oe_d;
    end
  end
  assign dq_out   = dq_q;
  assign dq_oe    = oe_q;
  assign dqs_out  = dqs_q;
  assign dqs_oe   = oe_q;
  assign cfg_addr = addr_q;
  assign busy     = busy_q;
endmodule

/* File: src/mrr_params.svh */
`ifndef MRR_PARAMS_SVH
`define MRR_PARAMS_SVH
// Functional notes
// - read command: select low, lines 3..0 = 1000
// - address: falling bits 1..0, rising bits 9..4
// - first beat carries register byte after latency
// - other beats, upper lanes: defined-level filler
// - pattern registers: every beat carries pattern
// - all strobe pairs toggle whole burst
// - read burst always eight beats
// - temperature status readable by mode read
// - temperature status refreshed within 32 ms
// - two fixed calibration pattern registers
// - patterns A 10101010, B 00110010 bit times
// - pattern reads: each lane replicates its lowest line
`define MRR_ADDR_TEMP      8'h04
`define MRR_ADDR_PAT_A     8'h20
`define MRR_ADDR_PAT_B     8'h28
`define MRR_PAT_A          8'h55
`define MRR_PAT_B          8'h4C
`define MRR_BEATS          4'h8
`define MRR_READ_LAT       8
`define MRR_TSI_MS         32
`define MRR_CLK_MHZ        250
`define MRR_TSI_CYC        (`MRR_TSI_MS * 1000 * `MRR_CLK_MHZ)
`define MRR_TEMP_RST       8'h03
`endif

/* File: src/mrr_pkg.sv */
package mrr_pkg;
  // burst engine states
  typedef enum logic [1:0] {
    MRR_IDLE = 2'b00,
    MRR_WAIT = 2'b01,
    MRR_BURST = 2'b10
  } mrr_state_t;
  // kind of register being read
  typedef enum logic [1:0] {
    MRR_K_PLAIN = 2'b00,
    MRR_K_PAT_A = 2'b01,
    MRR_K_PAT_B = 2'b10
  } mrr_kind_t;
endpackage

/* File: src/mrr_req_if.sv */
`timescale 1ns/1ps
// carries a decoded read request from the decoder to the burst engine
interface mrr_req_if;
  logic                 valid;  // one-cycle request pulse
  logic [7:0]           addr;   // register address
  mrr_pkg::mrr_kind_t   kind;   // plain or pattern
  modport src (output valid, output addr, output kind);
  modport dst (input valid, input addr, input kind);
endinterface

/* File: src/mrr_decode.sv */
`timescale 1ns/1ps
`include "mrr_params.svh"
// decodes the command bus; rising half and falling half come as one pair
module mrr_decode (
  // clock and reset
  input  wire logic    clk_sys,
  input  wire logic    rst_b,
  // synchronised command bus
  input  wire logic    cs_b,
  input  wire logic [9:0] ca_rise,
  input  wire logic [9:0] ca_fall,
  // decoded request
  mrr_req_if.src       req
);
  import mrr_pkg::*;
  logic              valid_q, valid_d;
  logic [7:0]        addr_q, addr_d;
  mrr_kind_t         kind_q, kind_d;
  // next-value decode
  always_comb begin
    valid_d = ~cs_b & (ca_rise[3:0] == 4'h8);
    addr_d  = {ca_rise[9:4], ca_fall[1:0]};
    if (addr_d == `MRR_ADDR_PAT_A) begin
      kind_d = MRR_K_PAT_A;
    end else if (addr_d == `MRR_ADDR_PAT_B) begin
      kind_d = MRR_K_PAT_B;
    end else begin
      kind_d = MRR_K_PLAIN;
    end
  end
  // register the decode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      valid_q <= 1'b0;
      addr_q  <= 8'h00;
      kind_q  <= MRR_K_PLAIN;
    end else begin
      valid_q <= valid_d;
      addr_q  <= addr_d;
      kind_q  <= kind_d;
    end
  end
  assign req.valid = valid_q;
  assign req.addr  = addr_q;
  assign req.kind  = kind_q;
endmodule

/* File: src/mrr_temp.sv */
`timescale 1ns/1ps
`include "mrr_params.svh"
// temperature status: samples the sensor code at a fixed interval
module mrr_temp #(
  parameter int unsigned TSI_CYC = `MRR_TSI_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // sensor side (already synchronised)
  input  wire logic [7:0] sensor_code,
  input  wire logic       lp_exit,
  // held status
  output logic [7:0]      temp_status
);
  logic [31:0] cnt_q, cnt_d;
  logic [7:0]  stat_q, stat_d;
  // update on interval wrap or on leaving a low-power state
  always_comb begin
    cnt_d  = cnt_q + 32'd1;
    stat_d = stat_q;
    if (lp_exit || cnt_q >= TSI_CYC - 1) begin
      cnt_d  = 32'd0;
      stat_d = sensor_code;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= 32'd0;
      stat_q <= `MRR_TEMP_RST;
    end else begin
      cnt_q  <= cnt_d;
      stat_q <= stat_d;
    end
  end
  assign temp_status = stat_q;
endmodule

/* File: verification/mrr_host.sv */
`timescale 1ns/1ps
// controller side: one command cycle, then a quiet gap
module mrr_host #(
  parameter int unsigned READ_LAT = 8
) (
  // clock
  input  wire logic  clk_sys,
  // command bus
  output logic       cs_b,
  output logic [9:0] ca_rise,
  output logic [9:0] ca_fall
);
  initial begin
    cs_b    = 1'b1;
    ca_rise = 10'h000;
    ca_fall = 10'h000;
  end
  // deselected lines flip so a stale value never looks like a command
  task automatic send(input logic cs, input logic [9:0] r, input logic [9:0] f);
    @(posedge clk_sys);
    #1;
    cs_b    = cs;
    ca_rise = r;
    ca_fall = f;
    @(posedge clk_sys);
    #1;
    cs_b    = 1'b1;
    ca_rise = ~r;
    ca_fall = ~f;
    // gap covers burst plus read-to-write spacing; nothing else is issued
    repeat (READ_LAT + 16) @(posedge clk_sys);
    #1;
  endtask
  // mode read: lines 3..0 = 1000, address split over both halves
  task automatic mrr(input logic [7:0] a);
    send(1'b0, {a[7:2], 4'h8}, {8'h00, a[1:0]});
  endtask
endmodule

/* File: verification/mrr_top_monitor.sv */
`timescale 1ns/1ps
`include "mrr_params.svh"
// watches the read-back pins of mrr_top
module mrr_top_monitor #(
  parameter int unsigned READ_LAT = 8,
  parameter int unsigned LANES    = 4
) (
  input wire logic               clk_sys,
  input wire logic               rst_b,
  input wire logic               cs_b,
  input wire logic [9:0]         ca_rise,
  input wire logic [9:0]         ca_fall,
  input wire logic [7:0]         cfg_byte,
  input wire logic [8*LANES-1:0] dq_out,
  input wire logic               dq_oe,
  input wire logic [LANES-1:0]   dqs_out,
  input wire logic               dqs_oe,
  input wire logic [7:0]         cfg_addr,
  input wire logic               busy
);
  localparam int         LAT_LO = READ_LAT - 1;
  localparam int         LAT_HI = READ_LAT + 1;
  localparam logic [7:0] PAV    = 8'h55;
  localparam logic [7:0] PBV    = 8'h4C;
  logic [2:0] beat_q;   // beat number inside the burst
  logic [2:0] beat_d;
  logic       cmd;      // read command seen while idle
  logic       pat;      // pattern register addressed
  assign cmd = !cs_b && ca_rise[3:0] == 4'h8 && !busy;
  assign pat = cfg_addr == `MRR_ADDR_PAT_A || cfg_addr == `MRR_ADDR_PAT_B;
  always_comb beat_d = dq_oe ? beat_q + 3'h1 : 3'h0;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) beat_q <= 3'h0;
    else beat_q <= beat_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_cmd_start: assert property (cmd |-> ##[3:5] busy) else $error("read not started");
  a_addr_take: assert property (cmd |-> ##6 cfg_addr == {$past(ca_rise[9:4], 6), $past(ca_fall[1:0], 6)})
    else $error("address mismatch");
  a_first_beat: assert property ($rose(busy) |-> ##[LAT_LO:LAT_HI] $rose(dq_oe)) else $error("latency");
  a_plain_byte: assert property ($rose(dq_oe) && !pat && cfg_addr != `MRR_ADDR_TEMP |->
    dq_out[7:0] == cfg_byte) else $error("first beat byte");
  a_burst_len: assert property ($rose(dq_oe) |-> dq_oe[*8] ##1 !dq_oe) else $error("burst length");
  a_strobe_oe: assert property (dqs_oe == dq_oe) else $error("strobe enable");
  a_strobe_flip: assert property (dq_oe && $past(dq_oe) |-> dqs_out == ~$past(dqs_out))
    else $error("strobe not toggling");
  a_oe_busy: assert property (dq_oe |-> busy) else $error("drive outside read");
  a_pat_bits: assert property (dq_oe && pat |->
    dq_out[0] == (cfg_addr == `MRR_ADDR_PAT_A ? PAV[beat_q] : PBV[beat_q])) else $error("pattern bit");
  a_lane_copy: assert property (dq_oe && pat |-> dq_out == {(8*LANES){dq_out[0]}}) else $error("lane copy");
  c_plain: cover property ($rose(dq_oe) && !pat);
  c_pat: cover property ($rose(dq_oe) && pat);
  c_temp: cover property ($rose(dq_oe) && cfg_addr == `MRR_ADDR_TEMP);
endmodule
bind mrr_top mrr_top_monitor #(.READ_LAT(READ_LAT), .LANES(LANES)) mrr_top_monitor_inst (.clk_sys(clk_sys),
  .rst_b(rst_b), .cs_b(cs_b), .ca_rise(ca_rise), .ca_fall(ca_fall), .cfg_byte(cfg_byte), .dq_out(dq_out),
  .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .cfg_addr(cfg_addr), .busy(busy));

/* File: verification/mrr_top_tb.sv */
`timescale 1ns/1ps
// reads plain, pattern and temperature registers through the host model
module mrr_top_tb;
  logic        clk_sys, rst_b, lp_exit, dq_oe, dqs_oe, busy, cs_b;
  logic [7:0]  cfg_byte, sensor_code, cfg_addr;
  logic [9:0]  ca_rise, ca_fall;
  logic [31:0] dq_out;
  logic [3:0]  dqs_out;
  logic [31:0] bt [8];  // captured beats
  logic [3:0]  st [8];  // captured strobes
  int          bad_count = 0, checks = 0, cyc = 0;
  mrr_host #(.READ_LAT(8)) mrr_host_inst (.clk_sys(clk_sys), .cs_b(cs_b), .ca_rise(ca_rise), .ca_fall(ca_fall));
  mrr_top #(.READ_LAT(8), .TSI_CYC(50), .LANES(4)) mrr_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b),
    .ca_rise(ca_rise), .ca_fall(ca_fall), .cfg_byte(cfg_byte), .sensor_code(sensor_code), .lp_exit(lp_exit),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .cfg_addr(cfg_addr), .busy(busy));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // bounded wait for the burst, then capture all eight beats
  task automatic grab();
    int n;
    n = 0;
    while (dq_oe !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    for (int i = 0; i < 8; i++) begin
      bt[i] = dq_out;
      st[i] = dqs_out;
      chk({30'h0, dq_oe, dqs_oe}, 32'h3);
      @(posedge clk_sys);
      #1;
    end
    chk({30'h0, dq_oe, dqs_oe}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a);
    fork
      mrr_host_inst.mrr(a);
      grab();
    join
  endtask
  // plain registers: byte on first beat only, strobes alternate from high
  task automatic t_plain();
    logic [7:0] ad [2] = '{8'h35, 8'hCA};
    for (int k = 0; k < 2; k++) begin
      cfg_byte = 8'hA7 ^ ad[k];
      rd(ad[k]);
      chk({24'h0, cfg_addr}, {24'h0, ad[k]});
      chk(bt[0], {24'h0, 8'hA7 ^ ad[k]});
      for (int i = 0; i < 8; i++) begin
        chk({28'h0, st[i]}, {28'h0, i[0] ? 4'h0 : 4'hF});
        if (i > 0) chk(bt[i], 32'h0);
      end
    end
    $display("plain reads done");
  endtask
  // calibration patterns: every beat and every line follows the pattern bit
  task automatic t_pat();
    logic [7:0] p;
    for (int k = 0; k < 2; k++) begin
      p = k ? 8'h4C : 8'h55;
      rd(k ? 8'h28 : 8'h20);
      for (int i = 0; i < 8; i++) chk(bt[i], {32{p[i]}});
    end
    $display("pattern reads done");
  endtask
  // other encodings and a deselected read must never start a burst
  task automatic t_neg();
    logic [4:0] c [4] = '{5'h00, 5'h18, 5'h09, 5'h0C};
    for (int k = 0; k < 4; k++) begin
      fork
        mrr_host_inst.send(c[k][4], {6'h0, c[k][3:0]}, 10'h000);
        begin
          repeat (12) @(posedge clk_sys);
          #1;
          chk({30'h0, busy, dq_oe}, 32'h0);
        end
      join
    end
    $display("non-read commands done");
  endtask
  // low-power exit refreshes status at once, the interval does it later
  task automatic t_temp();
    sensor_code = 8'h2B;
    @(posedge clk_sys);
    #1;
    lp_exit = 1'b1;
    @(posedge clk_sys);
    #1;
    lp_exit = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    // the exit restarted the interval, so this new code stays hidden until the next wrap
    sensor_code = 8'h61;
    rd(8'h04);
    chk(bt[0], {24'h0, 8'h2B});
    repeat (60) @(posedge clk_sys);
    rd(8'h04);
    chk(bt[0], {24'h0, 8'h61});
    $display("temperature reads done");
  endtask
  initial begin
    rst_b       = 1'b0;
    lp_exit     = 1'b0;
    cfg_byte    = 8'h00;
    sensor_code = 8'h03;
    repeat (12) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    t_plain();
    t_pat();
    t_neg();
    t_temp();
    summarize();
  end
  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      $display("[FAIL] %0t ns: run timed out", $time);
      summarize();
    end
  end
endmodule
